// ===== hw/tmr_pkg.sv
// Constants, register map and state type for the timer control block
// Behaviour
// RL1: Channel interrupt enable bit gates the same-position channel flag onto the interrupt.
// RL2: Overflow interrupt enable requests an interrupt while the overflow flag is set.
// RL3: Counter reset enable makes a channel 7 compare reset the main counter.
// RL4: Reset enable with channel 7 value zero holds the counter at zero.
// RL5: Reset enable with channel 7 at all ones never sets overflow.
// RL6: Prescale select divides the bus clock by two to the field value.
// RL7: New prescale factor applies only when all prescale counter stages are zero.
// RL8: Channel flag sets on its input capture or output compare event.
// RL9: Writing one clears a channel flag; writing zero leaves it.
// RL10: With fast clear, capture-mode read or compare-mode write clears channel flag.
// RL11: Overflow flag sets when the main counter rolls from all ones to zero.
// RL12: Writing the overflow flag register with bit 7 set clears overflow.
// RL13: With fast clear, any main counter read or write clears overflow.
// RL14: Capture mode latches counter on event; compare mode value triggers compare.
// RL15: Channel value writes work in compare mode and are ignored in capture mode.
// RL16: All channel capture and compare values reset to zero.
// RL17: Software reading a value as bytes takes high byte before low byte.
// RL18: Clearing timer enable stops the prescaler and main counter.
// RL19: A compare event occurs in the tick where counter equals channel value.
package tmr_pkg;

    // Register indices, byte address is four times the index
    localparam logic [5:0] IDX_MODE_SELECT   = 6'h00;
    localparam logic [5:0] IDX_MAIN_COUNTER  = 6'h04;
    localparam logic [5:0] IDX_SYS_CONTROL   = 6'h06;
    localparam logic [5:0] IDX_INT_ENABLE    = 6'h0C;
    localparam logic [5:0] IDX_SYS_CONTROL2  = 6'h0D;
    localparam logic [5:0] IDX_CHANNEL_FLAG  = 6'h0E;
    localparam logic [5:0] IDX_OVERFLOW_FLAG = 6'h0F;
    localparam logic [5:0] IDX_CHANNEL_FIRST = 6'h10;
    localparam logic [5:0] IDX_CHANNEL_LAST  = 6'h1F;
    localparam logic [5:0] IDX_CHANNEL_FOUR  = 6'h18;
    localparam logic [5:0] IDX_EVENT_STATUS  = 6'h30;
    localparam logic [5:0] IDX_EVENT_MASK    = 6'h31;
    localparam int         ADDR_LSB          = 2;
    localparam int         ADDR_MSB          = 7;

    // Field positions
    localparam int BIT_TIMER_ENABLE  = 7;
    localparam int BIT_FAST_CLEAR    = 4;
    localparam int BIT_OVF_INT_EN    = 7;
    localparam int BIT_CNT_RESET_EN  = 3;
    localparam int BIT_OVERFLOW_FLAG = 7;
    localparam int PRESCALE_MSB      = 2;
    localparam int CHAN_LOW_BIT      = 4;
    localparam int CHAN_COUNT        = 4;
    localparam int EVT_OVERFLOW      = 4;

    // Widths, values, responses
    localparam int          PRESCALE_STAGES = 7;
    localparam logic [15:0] COUNTER_MAX     = 16'hFFFF;
    localparam logic [15:0] CHANNEL_RESET   = 16'h0000;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;

    typedef struct packed {
        logic                        awReady;
        logic                        wReady;
        logic                        awHeld;
        logic                        wHeld;
        logic [5:0]                  awIdx;
        logic [31:0]                 wData;
        logic [3:0]                  wStrb;
        logic                        bValid;
        logic                        arReady;
        logic                        rValid;
        logic [31:0]                 rData;
        logic                        timerEnable;
        logic                        fastFlagClear;
        logic [3:0]                  modeSelect;
        logic [3:0]                  intEnable;
        logic [3:0]                  chFlag;
        logic                        ovfIntEnable;
        logic                        counterResetEnable;
        logic [2:0]                  prescaleSelect;
        logic [2:0]                  activeSelect;
        logic [PRESCALE_STAGES-1:0]  prescaleCount;
        logic                        overflowFlag;
        logic [15:0]                 mainCounter;
        logic [3:0][15:0]            chValue;
        logic [4:0]                  eventStatus;
        logic [4:0]                  eventMask;
        logic                        flagIrq;
        logic                        eventIrq;
        logic [3:0]                  compareEvent;
    } tmr_state_t;

endpackage

// ===== hw/tmr_timer_regs.sv
// Timer control, prescaler, flags and channel 4..7 registers behind AXI4-Lite
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module tmr_timer_regs (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // AXI4-Lite write address and data
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Capture events from the edge detectors, channels 4..7
    input  wire logic [3:0]  captureEvent,
    // Links to the rest of the timer
    output logic [15:0]      mainCounter,
    output logic [3:0]       channelModeSelect,
    output logic             fastFlagClear,
    output logic             timerEnable,
    output logic [3:0]       compareEvent,
    // Interrupts
    output logic             flagIrq,
    output logic             eventIrq
);

    tmr_pkg::tmr_state_t s;
    tmr_pkg::tmr_state_t next_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic        tick;
        logic        cmp7Reset;
        logic [3:0]  chSet;
        logic [3:0]  chClr;
        logic        ovfSet;
        logic        ovfClr;
        logic [4:0]  evtClr;
        logic [6:0]  stageMask;
        logic [5:0]  rIdx;
        logic        doWrite;
        logic [31:0] rd;
        int          ch;

        next_s    = s;
        tick      = 1'b0;
        cmp7Reset = 1'b0;
        chSet     = '0;
        chClr     = '0;
        ovfSet    = 1'b0;
        ovfClr    = 1'b0;
        evtClr    = '0;
        rd        = '0;
        stageMask = '0;
        ch        = 0;
        rIdx      = s_axi_araddr[tmr_pkg::ADDR_MSB:tmr_pkg::ADDR_LSB];
        doWrite   = s.awHeld && s.wHeld && !s.bValid;
        next_s.compareEvent = '0;

        // RL18: enable gates prescaler
        if (s.timerEnable) begin
            next_s.prescaleCount = s.prescaleCount + 7'h01;
            // RL6: divide by power of two
            stageMask = 7'((8'h01 << s.activeSelect) - 8'h01);
            tick = ((s.prescaleCount & stageMask) == stageMask);
            // RL7: switch at zero stages
            if (s.prescaleCount == '0) begin
                next_s.activeSelect = s.prescaleSelect;
            end
        end

        // RL19: compare on equal count
        for (ch = 0; ch < tmr_pkg::CHAN_COUNT; ch++) begin
            if (tick && s.modeSelect[ch] && (s.mainCounter == s.chValue[ch])) begin
                next_s.compareEvent[ch] = 1'b1;
                chSet[ch] = 1'b1;
            end
            // RL14: capture latches counter
            if (captureEvent[ch] && !s.modeSelect[ch]) begin
                next_s.chValue[ch] = s.mainCounter;
                chSet[ch] = 1'b1; // RL8: capture sets flag
            end
        end

        // RL3: compare 7 resets counter
        cmp7Reset = s.counterResetEnable && next_s.compareEvent[tmr_pkg::CHAN_COUNT-1];
        if (tick) begin
            // RL4: zero value holds counter
            if (cmp7Reset) begin
                next_s.mainCounter = '0;
            end else begin
                next_s.mainCounter = s.mainCounter + 16'h0001;
                // RL11: rollover sets overflow
                ovfSet = (s.mainCounter == tmr_pkg::COUNTER_MAX); // RL5: reset path skips this
            end
        end

        // Write address and data accepted in either order
        if (s_axi_awvalid && s.awReady) begin
            next_s.awHeld = 1'b1;
            next_s.awIdx  = s_axi_awaddr[tmr_pkg::ADDR_MSB:tmr_pkg::ADDR_LSB];
        end
        if (s_axi_wvalid && s.wReady) begin
            next_s.wHeld = 1'b1;
            next_s.wData = s_axi_wdata;
            next_s.wStrb = s_axi_wstrb;
        end

        // Register write once both halves are held
        if (doWrite) begin
            next_s.awHeld = 1'b0;
            next_s.wHeld  = 1'b0;
            next_s.bValid = 1'b1;
            if (s.wStrb[0]) begin
                case (s.awIdx)
                    tmr_pkg::IDX_MODE_SELECT: begin
                        next_s.modeSelect = s.wData[7:tmr_pkg::CHAN_LOW_BIT];
                    end
                    tmr_pkg::IDX_SYS_CONTROL: begin
                        next_s.timerEnable   = s.wData[tmr_pkg::BIT_TIMER_ENABLE];
                        next_s.fastFlagClear = s.wData[tmr_pkg::BIT_FAST_CLEAR];
                    end
                    tmr_pkg::IDX_INT_ENABLE: begin
                        next_s.intEnable = s.wData[7:tmr_pkg::CHAN_LOW_BIT];
                    end
                    tmr_pkg::IDX_SYS_CONTROL2: begin
                        next_s.ovfIntEnable       = s.wData[tmr_pkg::BIT_OVF_INT_EN];
                        next_s.counterResetEnable = s.wData[tmr_pkg::BIT_CNT_RESET_EN];
                        next_s.prescaleSelect     = s.wData[tmr_pkg::PRESCALE_MSB:0];
                    end
                    // RL9: write one clears
                    tmr_pkg::IDX_CHANNEL_FLAG: begin
                        chClr = chClr | s.wData[7:tmr_pkg::CHAN_LOW_BIT];
                    end
                    // RL12: bit 7 clears overflow
                    tmr_pkg::IDX_OVERFLOW_FLAG: begin
                        ovfClr = ovfClr | s.wData[tmr_pkg::BIT_OVERFLOW_FLAG];
                    end
                    tmr_pkg::IDX_EVENT_MASK: begin
                        next_s.eventMask = s.wData[4:0];
                    end
                    default: begin
                    end
                endcase
            end
            // RL13: counter write clears overflow
            if (s.awIdx == tmr_pkg::IDX_MAIN_COUNTER && s.fastFlagClear) begin
                ovfClr = 1'b1;
            end
            for (ch = 0; ch < tmr_pkg::CHAN_COUNT; ch++) begin
                if (s.awIdx == tmr_pkg::IDX_CHANNEL_FOUR + 6'(2 * ch) && s.modeSelect[ch]) begin
                    // RL15: compare mode writes only
                    if (s.wStrb[0]) begin
                        next_s.chValue[ch][7:0] = s.wData[7:0];
                    end
                    if (s.wStrb[1]) begin
                        next_s.chValue[ch][15:8] = s.wData[15:8];
                    end
                    // RL10: compare write clears flag
                    if (s.fastFlagClear) begin
                        chClr[ch] = 1'b1;
                    end
                end
            end
        end

        // Write response
        if (s.bValid && s_axi_bready) begin
            next_s.bValid = 1'b0;
        end

        // Read of one register, answered in the next cycle
        if (s_axi_arvalid && s.arReady) begin
            next_s.rValid = 1'b1;
            case (rIdx)
                tmr_pkg::IDX_MODE_SELECT: begin
                    rd[7:tmr_pkg::CHAN_LOW_BIT] = s.modeSelect;
                end
                tmr_pkg::IDX_MAIN_COUNTER: begin
                    rd[15:0] = s.mainCounter;
                    ovfClr = ovfClr | s.fastFlagClear; // RL13: read clears overflow
                end
                tmr_pkg::IDX_SYS_CONTROL: begin
                    rd[tmr_pkg::BIT_TIMER_ENABLE] = s.timerEnable;
                    rd[tmr_pkg::BIT_FAST_CLEAR]   = s.fastFlagClear;
                end
                tmr_pkg::IDX_INT_ENABLE: begin
                    rd[7:tmr_pkg::CHAN_LOW_BIT] = s.intEnable;
                end
                tmr_pkg::IDX_SYS_CONTROL2: begin
                    rd[tmr_pkg::BIT_OVF_INT_EN]   = s.ovfIntEnable;
                    rd[tmr_pkg::BIT_CNT_RESET_EN] = s.counterResetEnable;
                    rd[tmr_pkg::PRESCALE_MSB:0]   = s.prescaleSelect;
                end
                tmr_pkg::IDX_CHANNEL_FLAG: begin
                    rd[7:tmr_pkg::CHAN_LOW_BIT] = s.chFlag;
                end
                tmr_pkg::IDX_OVERFLOW_FLAG: begin
                    rd[tmr_pkg::BIT_OVERFLOW_FLAG] = s.overflowFlag;
                end
                tmr_pkg::IDX_EVENT_STATUS: begin
                    rd[4:0] = s.eventStatus;
                    evtClr  = s.eventStatus; // Read clears status
                end
                tmr_pkg::IDX_EVENT_MASK: begin
                    rd[4:0] = s.eventMask;
                end
                default: begin
                end
            endcase
            for (ch = 0; ch < tmr_pkg::CHAN_COUNT; ch++) begin
                if (rIdx == tmr_pkg::IDX_CHANNEL_FOUR + 6'(2 * ch)) begin
                    rd[15:0] = s.chValue[ch];
                    // RL10: capture read clears flag
                    if (s.fastFlagClear && !s.modeSelect[ch]) begin
                        chClr[ch] = 1'b1;
                    end
                end
            end
            next_s.rData = rd;
        end else if (s.rValid && s_axi_rready) begin
            next_s.rValid = 1'b0;
        end

        // Flags: a set in the same cycle wins over any clear
        next_s.chFlag       = (s.chFlag & ~chClr) | chSet;
        next_s.overflowFlag = (s.overflowFlag & ~ovfClr) | ovfSet;
        next_s.eventStatus  = (s.eventStatus & ~evtClr) | {ovfSet, chSet};

        // RL1: per-channel enable gating
        // RL2: overflow enable gating
        next_s.flagIrq  = |(next_s.chFlag & next_s.intEnable)
                        | (next_s.overflowFlag & next_s.ovfIntEnable);
        next_s.eventIrq = |(next_s.eventStatus & next_s.eventMask);

        // Ready lines follow the holding state
        next_s.awReady = !next_s.awHeld && !next_s.bValid;
        next_s.wReady  = !next_s.wHeld && !next_s.bValid;
        next_s.arReady = !next_s.rValid;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register, RL16: values reset to zero
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s         <= '0;
            s.chValue <= {tmr_pkg::CHAN_COUNT{tmr_pkg::CHANNEL_RESET}};
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state, except bresp and rresp tied to okay
    assign s_axi_awready     = s.awReady;
    assign s_axi_wready      = s.wReady;
    assign s_axi_bvalid      = s.bValid;
    assign s_axi_bresp       = tmr_pkg::RESP_OKAY;
    assign s_axi_arready     = s.arReady;
    assign s_axi_rvalid      = s.rValid;
    assign s_axi_rdata       = s.rData;
    assign s_axi_rresp       = tmr_pkg::RESP_OKAY;
    assign mainCounter       = s.mainCounter;
    assign channelModeSelect = s.modeSelect;
    assign fastFlagClear     = s.fastFlagClear;
    assign timerEnable       = s.timerEnable;
    assign compareEvent      = s.compareEvent;
    assign flagIrq           = s.flagIrq;
    assign eventIrq          = s.eventIrq;

endmodule

// ===== tb/tmr_timer_regs_sva.sv
// Concurrent checks on the ports of the timer control block
`timescale 1ns/100ps
module tmr_timer_regs_sva (
    // Clock and reset
    input logic        clock,
    input logic        sys_rst,
    // Bus handshakes
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    // Timer links
    input logic [15:0] mainCounter,
    input logic [3:0]  channelModeSelect,
    input logic        timerEnable,
    input logic [3:0]  compareEvent
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    // Handshake steps that start a bus answer
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    // Write answers arrive two edges after the take, read answers one edge after, and both stand until accepted
    a_write_answer: assert property (s_write_taken |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == tmr_pkg::RESP_OKAY)
        else $error("write response not okay");
    a_read_answer: assert property (s_read_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer missing");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before acceptance");

    ////////////////////////////////////////////////////////////////////////////////
    // Counter behaviour and compare pulses
    a_counter_frozen: assert property (
        !timerEnable && !$past(timerEnable) && !$past(sys_rst) |-> $stable(mainCounter))
        else $error("counter moved while timer off");
    a_counter_step: assert property (
        !$past(sys_rst) |-> $stable(mainCounter) || mainCounter == 16'h0000
        || mainCounter == $past(mainCounter) + 16'h0001)
        else $error("counter jumped");
    a_compare_mode: assert property (
        |compareEvent |-> (($past(channelModeSelect) & compareEvent) == compareEvent)
        && $past(timerEnable))
        else $error("compare pulse outside compare mode");
endmodule

bind tmr_timer_regs tmr_timer_regs_sva i_tmr_timer_regs_sva (.*);

// ===== tb/tb.sv
// Self-checking bench for the timer control block
`timescale 1ns/100ps
module tb;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic [7:0]  awAddr = 8'h00, arAddr = 8'h00;
    logic [31:0] wData = 32'h0;
    logic [3:0]  captureEvent = 4'h0;
    logic [3:0]  wStrb = 4'hF;
    logic        awReady, wReady, bValid, arReady, rValid, flagIrq, eventIrq;
    logic        fastFlagClear, timerEnable;
    logic [1:0]  bResp, rResp;
    logic [31:0] rData;
    logic [15:0] mainCounter;
    logic [3:0]  channelModeSelect, compareEvent;
    int          failures = 0;
    int          checked = 0;

    always #2 clock = ~clock;

    tmr_timer_regs i_tmr_timer_regs (
        .clock(clock), .sys_rst(sys_rst),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
        .s_axi_awprot(3'h0), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_bresp(bResp), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_araddr(arAddr), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .captureEvent(captureEvent), .mainCounter(mainCounter),
        .channelModeSelect(channelModeSelect), .fastFlagClear(fastFlagClear),
        .timerEnable(timerEnable), .compareEvent(compareEvent), .flagIrq(flagIrq),
        .eventIrq(eventIrq));

    ////////////////////////////////////////////////////////////////////////////////
    // Compare, bus cycles and verdict
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data);
        awAddr  <= addr;
        wData   <= data;
        awValid <= 1'b1;
        wValid  <= 1'b1;
        bReady  <= 1'b1;
        do begin
            @(posedge clock);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
        end while (!bValid);
        bReady <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd_check(input string name, input logic [7:0] addr,
                            input logic [31:0] mask, input logic [31:0] exp);
        arAddr  <= addr;
        arValid <= 1'b1;
        rReady  <= 1'b1;
        do @(posedge clock); while (!arReady);
        arValid <= 1'b0;
        do @(posedge clock); while (!rValid);
        rReady <= 1'b0;
        check(name, exp, rData & mask);
        @(posedge clock);
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset_mode;
        rd_check("ch4 reset", 8'h60, 32'hFFFF, 32'h0);
        rd_check("ch7 reset", 8'h78, 32'hFFFF, 32'h0);
        rd_check("unmapped", 8'hFC, 32'hFFFFFFFF, 32'h0);
        axi_write(8'h60, 32'h1234);
        rd_check("capture write", 8'h60, 32'hFFFF, 32'h0);
        axi_write(8'h00, 32'hF0);
        // Byte-lane writes, high byte first
        wStrb <= 4'h2;
        axi_write(8'h60, 32'h3400);
        wStrb <= 4'h1;
        axi_write(8'h60, 32'h0056);
        wStrb <= 4'hF;
        rd_check("byte lanes", 8'h60, 32'hFFFF, 32'h3456);
        axi_write(8'h60, 32'h0040);
        rd_check("compare write", 8'h60, 32'hFFFF, 32'h0040);
        check("stopped counter", 32'h0, {16'h0, mainCounter});
    endtask

    task automatic t_compare;
        int n;
        axi_write(8'h30, 32'h10);
        axi_write(8'hC4, 32'h01);
        axi_write(8'h18, 32'h80);
        for (n = 0; n < 300 && compareEvent[0] !== 1'b1; n++) @(posedge clock);
        check("counter at compare", 32'h41, {16'h0, mainCounter});
        repeat (3) @(posedge clock);
        rd_check("flags set", 8'h38, 32'hFF, 32'hF0);
        check("flag irq", 32'h1, {31'h0, flagIrq});
        check("event irq", 32'h1, {31'h0, eventIrq});
        rd_check("event status", 8'hC0, 32'h1F, 32'h0F);
        check("event irq read", 32'h0, {31'h0, eventIrq});
        axi_write(8'h38, 32'h00);
        rd_check("flags kept", 8'h38, 32'hFF, 32'hF0);
        axi_write(8'h38, 32'h10);
        rd_check("one cleared", 8'h38, 32'hFF, 32'hE0);
        check("masked irq", 32'h0, {31'h0, flagIrq});
        axi_write(8'h30, 32'h00);
    endtask

    task automatic t_overflow;
        int n;
        axi_write(8'h34, 32'h80);
        for (n = 0; n < 70000 && mainCounter !== 16'hFFFF; n++) @(posedge clock);
        repeat (3) @(posedge clock);
        rd_check("overflow", 8'h3C, 32'hFF, 32'h80);
        rd_check("ovf status", 8'hC0, 32'h10, 32'h10);
        check("ovf irq", 32'h1, {31'h0, flagIrq});
        axi_write(8'h34, 32'h00);
        check("ovf irq off", 32'h0, {31'h0, flagIrq});
        axi_write(8'h3C, 32'h00);
        rd_check("ovf kept", 8'h3C, 32'hFF, 32'h80);
        axi_write(8'h3C, 32'h80);
        rd_check("ovf cleared", 8'h3C, 32'hFF, 32'h00);
    endtask

    task automatic t_modulus;
        logic [15:0] lim;
        logic [15:0] top;
        int          n;
        lim = mainCounter + 16'h0100;
        top = 16'h0000;
        axi_write(8'h78, {16'h0, lim});
        axi_write(8'h34, 32'h08);
        repeat (400) @(posedge clock);
        repeat (600) begin
            @(posedge clock);
            if (mainCounter > top) top = mainCounter;
        end
        check("modulus top", {16'h0, lim}, {16'h0, top});
        // Slow ticks so the zero compare is armed between two of them
        axi_write(8'h34, 32'h0F);
        repeat (300) @(posedge clock);
        lim = mainCounter + 16'h0002;
        axi_write(8'h78, {16'h0, lim});
        for (n = 0; n < 600 && compareEvent[3] !== 1'b1; n++) @(posedge clock);
        axi_write(8'h78, 32'h0);
        repeat (300) @(posedge clock);
        check("held at zero", 32'h0, {16'h0, mainCounter});
        axi_write(8'h34, 32'h00);
    endtask

    task automatic t_prescale;
        logic [15:0] last;
        int          n;
        for (int k = 0; k < 8; k++) begin
            axi_write(8'h34, k);
            repeat (260) @(posedge clock);
            last = mainCounter;
            for (n = 0; n < 300 && mainCounter === last; n++) @(posedge clock);
            last = mainCounter;
            for (n = 0; n < 300 && mainCounter === last; n++) @(posedge clock);
            check("tick spacing", 32'h1 << k, n);
        end
        // Just after a slow tick: a faster select must wait for the stages to reach zero
        last = mainCounter;
        axi_write(8'h34, 32'h00);
        repeat (32) @(posedge clock);
        check("prescale held", {16'h0, last}, {16'h0, mainCounter});
    endtask

    task automatic t_capture;
        logic [15:0] last;
        int          n;
        axi_write(8'h00, 32'hD0);
        axi_write(8'h38, 32'hF0);
        axi_write(8'h18, 32'h90);
        last = mainCounter;
        for (n = 0; n < 300 && mainCounter === last; n++) @(posedge clock);
        axi_write(8'h18, 32'h10);
        last = mainCounter;
        repeat (300) @(posedge clock);
        check("frozen counter", {16'h0, last}, {16'h0, mainCounter});
        check("mode out", 32'hD, {28'h0, channelModeSelect});
        check("fast clear out", 32'h1, {31'h0, fastFlagClear});
        captureEvent <= 4'h2;
        @(posedge clock);
        captureEvent <= 4'h0;
        repeat (3) @(posedge clock);
        rd_check("capture flag", 8'h38, 32'h20, 32'h20);
        rd_check("captured", 8'h68, 32'hFFFF, {16'h0, last});
        rd_check("fast cleared", 8'h38, 32'h20, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        t_reset_mode();
        t_compare();
        t_overflow();
        t_modulus();
        t_prescale();
        t_capture();
        final_report();
    end

    initial begin
        repeat (95000) @(posedge clock);
        failures++;
        final_report();
    end
endmodule
